// File: verilog/rmf_mode_flag.sv
// Mode code interpreter for terminal flag inhibit and transmitter shutdown override,
// with the exception handling shared by these commands, RAM bookkeeping and interrupts.
// Assumes decoded commands arrive as one-cycle pulses from the pclk-domain protocol engine.
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module rmf_mode_flag
  import rmf_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Decoded command from the protocol engine
  input wire logic cmd_valid,
  input wire rmf_cmd_type cmd,
  // Shutdown request from the transmitter shutdown command logic
  input wire logic shut_req,
  input wire logic shut_bus_b,
  // Hardware transmit inhibit pins
  input wire logic bus_a_tx_inhibit_pin,
  input wire logic bus_b_tx_inhibit_pin,
  // Status response to the encoder
  output logic status_req,
  output rmf_stat_type status_word,
  // Shared RAM write port
  output logic ram_wr,
  output logic [15:0] ram_addr,
  output logic [15:0] ram_wdata,
  // Bus shutdown bits and interrupt
  output rmf_shut_type bus_shut,
  output logic irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  rmf_state_type state_r;            // Bookkeeping sequence
  rmf_cmd_type cmd_r;                // Captured command
  logic [15:0] desc_nxt;             // Descriptor word to write
  logic [15:0] info_nxt;             // Info word to write
  logic [15:0] desc_r;               // Held descriptor word
  logic [15:0] info_r;               // Held info word
  logic [3:0] ev_nxt;                // Events of the classified command
  logic [3:0] ev_r;                  // Events held until RAM is written
  logic me_r;                        // Message error status bit
  logic bcr_r;                       // Broadcast received status bit
  logic tf_inh_r;                    // Terminal flag inhibit
  logic host_tf_r;                   // Host terminal flag request
  logic umc_inv_r;                   // Undefined mode invalid option
  logic shutdown_scope_select_r;                     // Shutdown scope select
  logic soft_reset_bit_r;                      // Soft reset pulse
  rmf_shut_type shut_r;              // Commanded shutdown bits
  logic [3:0] irq_stat_r;            // Sticky interrupt events
  logic [3:0] irq_mask_r;            // Interrupt enables
  logic [1:0] inh_pins;              // Synchronised inhibit pins
  logic [7:0] idx;                   // Register index of access
  logic wr_en;                       // Write completes this edge
  logic [31:0] rd_data;              // Read mux
  logic rd_hit;                      // Index is mapped
  logic ignore;                      // Classification results
  logic rx_code;
  logic bad_data;
  logic do_inh;
  logic do_ovr_shut;
  logic do_ovr_inh;
  logic do_rt_rst;
  logic known_tx;
  logic accept;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Mode codes handled here
  function automatic logic is_ours(input logic [4:0] mc);
    is_ours = (mc == RMF_MC_OVR_SHUT) || (mc == RMF_MC_INH_FLAG) ||
              (mc == RMF_MC_OVR_INH) || (mc == RMF_MC_RT_RST);
  endfunction

  // Info word with bus bit and chosen error bits, others zero
  function automatic logic [15:0] info_word(input logic bus_b, input logic message_fault_flag,
                                            input logic illegal_command_flag, input logic wct);
    logic [15:0] w;
    w = RMF_W16_ZERO;
    w[RMF_INFO_BUS] = bus_b;
    w[RMF_INFO_MESSAGE_FAULT_FLAG] = message_fault_flag;
    w[RMF_INFO_ILLEGAL_COMMAND_FLAG] = illegal_command_flag;
    w[RMF_INFO_WCT] = wct;
    info_word = w;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  rmf_sync2 #(
    .WIDTH(2)
  ) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({bus_b_tx_inhibit_pin, bus_a_tx_inhibit_pin}),
    .sync_out(inh_pins)
  );

  // ----------------------------------------------------------------
  // Command classification
  // ----------------------------------------------------------------
  // Decide the case of an arriving command
  always_comb
  begin
    accept = cmd_valid && (state_r == RMF_IDLE) && is_ours(cmd.mode);
    ignore = !cmd.valid_word || (!cmd.tr && umc_inv_r);
    bad_data = !ignore && cmd.data_follows;
    rx_code = !ignore && !bad_data && !cmd.tr;
    known_tx = !ignore && !bad_data && cmd.tr;
    do_ovr_shut = known_tx && (cmd.mode == RMF_MC_OVR_SHUT);
    do_inh = known_tx && (cmd.mode == RMF_MC_INH_FLAG);
    do_ovr_inh = known_tx && (cmd.mode == RMF_MC_OVR_INH);
    do_rt_rst = known_tx && (cmd.mode == RMF_MC_RT_RST);
  end

  // Descriptor, info word and events per case
  always_comb
  begin
    desc_nxt = cmd.desc;
    desc_nxt[RMF_DESC_PTR] = !cmd.desc[RMF_DESC_PTR];
    desc_nxt[RMF_DESC_BCST] = cmd.broadcast_msg_flag;
    desc_nxt[RMF_DESC_ACC] = 1'b0;
    info_nxt = info_word(cmd.bus_b, 1'b0, 1'b0, 1'b0);
    ev_nxt = RMF_IRQ_ZERO;
    if (bad_data)
    begin
      desc_nxt[RMF_DESC_ACC] = 1'b1;
      desc_nxt[RMF_DESC_BCST] = 1'b0;
      info_nxt = info_word(cmd.bus_b, 1'b1, 1'b0, 1'b1);
      ev_nxt[RMF_IRQ_ME] = 1'b1;
      ev_nxt[RMF_IRQ_WA] = 1'b1;
    end
    else if (rx_code)
    begin
      desc_nxt[RMF_DESC_ACC] = 1'b1;
      ev_nxt[RMF_IRQ_WA] = 1'b1;
      ev_nxt[RMF_IRQ_BR] = cmd.broadcast_msg_flag;
      if (cmd.illegal)
      begin
        info_nxt = info_word(cmd.bus_b, 1'b1, 1'b1, 1'b0);
        ev_nxt[RMF_IRQ_IL] = 1'b1;
      end
    end
    else
    begin
      // Valid transmit commands: accessed bit cleared, normal info
      ev_nxt[RMF_IRQ_WA] = 1'b1;
      ev_nxt[RMF_IRQ_BR] = cmd.broadcast_msg_flag;
    end
  end

  // ----------------------------------------------------------------
  // Bookkeeping sequence
  // ----------------------------------------------------------------
  // Capture, write descriptor, write info, then report
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= RMF_IDLE;
      cmd_r <= '0;
      desc_r <= RMF_W16_ZERO;
      info_r <= RMF_W16_ZERO;
      ev_r <= RMF_IRQ_ZERO;
    end
    else
    begin
      case (state_r)
        RMF_IDLE:
        begin
          // Ignored commands leave RAM untouched
          if (accept && !ignore)
          begin
            state_r <= RMF_WR_DESC;
            cmd_r <= cmd;
            desc_r <= desc_nxt;
            info_r <= info_nxt;
            ev_r <= ev_nxt;
          end
        end
        RMF_WR_DESC:
        begin
          state_r <= RMF_WR_INFO;
        end
        RMF_WR_INFO:
        begin
          state_r <= RMF_REPORT;
        end
        RMF_REPORT:
        begin
          state_r <= RMF_IDLE;
        end
        default:
        begin
          state_r <= RMF_IDLE;
        end
      endcase
    end
  end

  // RAM write port, one word per cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ram_wr <= 1'b0;
      ram_addr <= RMF_W16_ZERO;
      ram_wdata <= RMF_W16_ZERO;
    end
    else
    begin
      ram_wr <= 1'b0;
      if (state_r == RMF_WR_DESC)
      begin
        ram_wr <= 1'b1;
        ram_addr <= cmd_r.desc_addr;
        ram_wdata <= desc_r;
      end
      else if (state_r == RMF_WR_INFO)
      begin
        ram_wr <= 1'b1;
        ram_addr <= cmd_r.info_addr;
        ram_wdata <= info_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status word and response
  // ----------------------------------------------------------------
  // Message error and broadcast received bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      me_r <= 1'b0;
      bcr_r <= 1'b0;
    end
    else if (soft_reset_bit_r || (accept && do_rt_rst))
    begin
      me_r <= 1'b0;
      bcr_r <= 1'b0;
    end
    else if (accept && !ignore)
    begin
      me_r <= bad_data || (rx_code && cmd.illegal);
      bcr_r <= cmd.broadcast_msg_flag && !bad_data;
    end
  end

  // Response request, suppressed on broadcast and data fault
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_req <= 1'b0;
    end
    else
    begin
      status_req <= accept && !ignore && !bad_data && !cmd.broadcast_msg_flag;
    end
  end

  // Status bits seen by the encoder
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_word <= '0;
    end
    else
    begin
      status_word.me <= me_r;
      status_word.bcr <= bcr_r;
      status_word.tflag <= host_tf_r && !tf_inh_r;
    end
  end

  // Terminal flag inhibit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tf_inh_r <= 1'b0;
    end
    else if (soft_reset_bit_r || (accept && (do_ovr_inh || do_rt_rst)))
    begin
      tf_inh_r <= 1'b0;
    end
    else if (accept && do_inh)
    begin
      tf_inh_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Bus shutdown
  // ----------------------------------------------------------------
  // Commanded shutdown bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shut_r <= '0;
    end
    else if (soft_reset_bit_r || (accept && (do_ovr_shut || do_rt_rst)))
    begin
      shut_r <= '0;
    end
    else if (shut_req)
    begin
      shut_r.tx_a <= shut_r.tx_a || !shut_bus_b;
      shut_r.tx_b <= shut_r.tx_b || shut_bus_b;
      shut_r.rx_a <= shut_r.rx_a || (!shut_bus_b && !shutdown_scope_select_r);
      shut_r.rx_b <= shut_r.rx_b || (shut_bus_b && !shutdown_scope_select_r);
    end
  end

  // Effective shutdown, pins cannot be overridden
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bus_shut <= '0;
    end
    else
    begin
      bus_shut.tx_a <= shut_r.tx_a || inh_pins[0];
      bus_shut.tx_b <= shut_r.tx_b || inh_pins[1];
      bus_shut.rx_a <= shut_r.rx_a;
      bus_shut.rx_b <= shut_r.rx_b;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Sticky events; a new event wins over a clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat_r <= RMF_IRQ_ZERO;
    end
    else
    begin
      irq_stat_r <= (irq_stat_r & ~((wr_en && idx == RMF_IDX_IRQ_STAT) ? pwdata[3:0] : RMF_IRQ_ZERO))
                    | ((state_r == RMF_REPORT) ? ev_r : RMF_IRQ_ZERO);
    end
  end

  // Level interrupt output
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign idx = paddr[RMF_ADDR_LSB +: 8];
  assign wr_en = psel && penable && pready && pwrite;

  // Read mux and address decode
  always_comb
  begin
    rd_data = RMF_ZERO;
    rd_hit = 1'b1;
    case (idx)
      RMF_IDX_CFG1: rd_data[RMF_CFG1_UMC_INV] = umc_inv_r;
      RMF_IDX_CFG2: rd_data[RMF_CFG2_SHUTDOWN_SCOPE_SELECT] = shutdown_scope_select_r;
      RMF_IDX_STBITS: rd_data[RMF_STB_TFLAG] = host_tf_r;
      RMF_IDX_IRQ_STAT: rd_data[3:0] = irq_stat_r;
      RMF_IDX_IRQ_MASK: rd_data[3:0] = irq_mask_r;
      RMF_IDX_LAST: rd_data = {info_r, desc_r};
      RMF_IDX_BITWORD: rd_data[RMF_BITW_TFINH] = tf_inh_r;
      RMF_IDX_BITREG: rd_data[3:0] = bus_shut;
      default: rd_hit = 1'b0;
    endcase
  end

  // No wait state: answer in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= RMF_ZERO;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !rd_hit;
      prdata <= (psel && !penable && !pwrite) ? rd_data : RMF_ZERO;
    end
  end

  // Host writable configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      umc_inv_r <= 1'b0;
      shutdown_scope_select_r <= 1'b0;
      host_tf_r <= 1'b0;
      irq_mask_r <= RMF_IRQ_ZERO;
      soft_reset_bit_r <= 1'b0;
    end
    else
    begin
      soft_reset_bit_r <= wr_en && (idx == RMF_IDX_CFG1) && pwdata[RMF_CFG1_SOFT_RESET_BIT];
      if (wr_en && (idx == RMF_IDX_CFG1))
        umc_inv_r <= pwdata[RMF_CFG1_UMC_INV];
      if (wr_en && (idx == RMF_IDX_CFG2))
        shutdown_scope_select_r <= pwdata[RMF_CFG2_SHUTDOWN_SCOPE_SELECT];
      if (wr_en && (idx == RMF_IDX_STBITS))
        host_tf_r <= pwdata[RMF_STB_TFLAG];
      if (wr_en && (idx == RMF_IDX_IRQ_MASK))
        irq_mask_r <= pwdata[3:0];
    end
  end

endmodule
`default_nettype wire

// File: shared/rmf_pkg.sv
// Constants, field layouts and carrier types for the mode code flag/shutdown interpreter.
// Assumes a 10 MHz pclk and 32-bit APB word registers at four times each register index.
package rmf_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] RMF_IDX_CFG1 = 8'h01;      // Option and soft reset bits
  localparam logic [7:0] RMF_IDX_CFG2 = 8'h02;      // Shutdown scope select
  localparam logic [7:0] RMF_IDX_STBITS = 8'h06;    // Host status bits (terminal flag)
  localparam logic [7:0] RMF_IDX_IRQ_STAT = 8'h10;  // Sticky event bits, write one to clear
  localparam logic [7:0] RMF_IDX_IRQ_MASK = 8'h11;  // Enable per event bit
  localparam logic [7:0] RMF_IDX_LAST = 8'h12;      // Last descriptor and info words
  localparam logic [7:0] RMF_IDX_BITWORD = 8'h13;   // Built-in-test word (flag inhibit)
  localparam logic [7:0] RMF_IDX_BITREG = 8'h14;    // Bus shutdown bits
  localparam int RMF_ADDR_LSB = 2;                  // Word aligned byte addresses

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RMF_CFG1_UMC_INV = 0;   // Undefined mode codes count as invalid
  localparam int RMF_CFG1_SOFT_RESET_BIT = 1;      // Soft reset, reads as zero
  localparam int RMF_CFG2_SHUTDOWN_SCOPE_SELECT = 0;     // 0: shut tx and rx, 1: tx only
  localparam int RMF_STB_TFLAG = 0;      // Host terminal flag request
  localparam int RMF_BITW_TFINH = 0;     // Terminal flag inhibit
  localparam int RMF_DESC_ACC = 4;       // Descriptor accessed bit
  localparam int RMF_DESC_BCST = 5;      // Broadcast flag
  localparam int RMF_DESC_PTR = 6;       // Buffer pointer bit
  localparam int RMF_INFO_BUS = 15;      // Receiving bus (1 = bus B)
  localparam int RMF_INFO_MESSAGE_FAULT_FLAG = 14;     // Message fault
  localparam int RMF_INFO_ILLEGAL_COMMAND_FLAG = 13;    // Illegal command
  localparam int RMF_INFO_TERMINAL_TO_TERMINAL_FLAG = 12;     // Terminal to terminal
  localparam int RMF_INFO_WCT = 11;      // Word count fault
  localparam int RMF_INFO_ERR_LSB = 8;   // Remaining error bits 10:8

  // ----------------------------------------------------------------
  // Mode codes and reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] RMF_MC_OVR_SHUT = 5'h05;  // Override transmitter shutdown
  localparam logic [4:0] RMF_MC_INH_FLAG = 5'h06;  // Inhibit terminal flag
  localparam logic [4:0] RMF_MC_OVR_INH = 5'h07;   // Override flag inhibit
  localparam logic [4:0] RMF_MC_RT_RST = 5'h08;    // Remote terminal reset
  localparam logic [31:0] RMF_ZERO = 32'h0000_0000;
  localparam logic [3:0] RMF_IRQ_ZERO = 4'h0;
  localparam logic [15:0] RMF_W16_ZERO = 16'h0000;

  // Interrupt bit positions
  localparam int RMF_IRQ_WA = 0;   // Word access
  localparam int RMF_IRQ_BR = 1;   // Broadcast received
  localparam int RMF_IRQ_IL = 2;   // Illegal command
  localparam int RMF_IRQ_ME = 3;   // Message error

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic valid_word;     // Command word passed validity checks
    logic tr;             // Transmit/receive bit
    logic broadcast_msg_flag;          // Broadcast address
    logic [4:0] mode;     // Mode code field
    logic bus_b;          // Received on bus B
    logic data_follows;   // Contiguous data word after mode command
    logic illegal;        // Illegalization table entry
    logic [15:0] desc;    // Current descriptor control word
    logic [15:0] desc_addr;  // RAM address of the descriptor
    logic [15:0] info_addr;  // RAM address of the message info word
  } rmf_cmd_type;

  typedef struct packed
  {
    logic me;      // Message error
    logic bcr;     // Broadcast command received
    logic tflag;   // Terminal flag
  } rmf_stat_type;

  typedef struct packed
  {
    logic tx_a;
    logic tx_b;
    logic rx_a;
    logic rx_b;
  } rmf_shut_type;

  typedef enum logic [2:0]
  {
    RMF_IDLE = 3'b000,
    RMF_WR_DESC = 3'b001,
    RMF_WR_INFO = 3'b010,
    RMF_REPORT = 3'b011
  } rmf_state_type;

endpackage

// File: verilog/rmf_sync2.sv
// Two flip-flop level synchroniser for asynchronous pins.
// Assumes the inputs are quasi-static levels from outside the pclk domain.
`timescale 1ns/10ps
`default_nettype none
module rmf_sync2 #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;  // First stage, read only by the second

  // Two stage capture
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule
`default_nettype wire

// File: tb/rmf_mode_flag_sva.sv
// Checker on the ports of rmf_mode_flag.
// Assumes commands are spaced well beyond the four-cycle busy time.
`timescale 1ns/10ps
`default_nettype none
module rmf_chk
  import rmf_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Watched ports
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic cmd_valid,
  input wire rmf_cmd_type cmd,
  input wire logic bus_a_tx_inhibit_pin,
  input wire logic status_req,
  input wire rmf_stat_type status_word,
  input wire logic ram_wr,
  input wire rmf_shut_type bus_shut,
  input wire logic irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Valid transmit command without data word
  wire logic ok_tx;
  assign ok_tx = cmd_valid && cmd.valid_word && cmd.tr && !cmd.data_follows;

  property p_ign;
    cmd_valid && !cmd.valid_word |-> ##1 !status_req ##1 !ram_wr [*3];
  endproperty
  a_ign: assert property (p_ign) else $error("ignored command caused activity");
  property p_sreq;
    status_req |-> $past(cmd_valid && cmd.valid_word && !cmd.data_follows && !cmd.broadcast_msg_flag);
  endproperty
  a_sreq: assert property (p_sreq) else $error("status request without cause");
  property p_inh;
    ok_tx && cmd.mode == RMF_MC_INH_FLAG |-> ##2 !status_word.me && !status_word.tflag ##1 !status_word.tflag [*4];
  endproperty
  a_inh: assert property (p_inh) else $error("flag not inhibited");
  property p_df;
    cmd_valid && cmd.valid_word && cmd.tr && cmd.data_follows |-> ##1 !status_req ##1 status_word.me;
  endproperty
  a_df: assert property (p_df) else $error("data word case wrong");
  property p_ram;
    ok_tx |-> ##2 ram_wr ##1 ram_wr ##1 !ram_wr;
  endproperty
  a_ram: assert property (p_ram) else $error("ram writes missing");
  property p_irq;
    $rose(irq) |-> $past(psel) || $past(ram_wr, 2);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt before ram write");
  property p_pin;
    bus_a_tx_inhibit_pin [*4] |-> bus_shut.tx_a;
  endproperty
  a_pin: assert property (p_pin) else $error("inhibit pin overridden");
  property p_ovr;
    ok_tx && cmd.mode == RMF_MC_OVR_SHUT |-> ##2 !bus_shut.rx_a && !bus_shut.rx_b;
  endproperty
  a_ovr: assert property (p_ovr) else $error("receive not re-enabled");
  property p_rdy;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready timing wrong");
endmodule

bind rmf_mode_flag rmf_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .cmd_valid(cmd_valid), .cmd(cmd), .bus_a_tx_inhibit_pin(bus_a_tx_inhibit_pin),
  .status_req(status_req), .status_word(status_word), .ram_wr(ram_wr), .bus_shut(bus_shut), .irq(irq));
`default_nettype wire

// File: tb/rmf_bc_model.sv
// Bus controller model: issues one decoded command per request, counts responses.
// Assumes go is a one-cycle pulse from the bench.
`timescale 1ns/10ps
`default_nettype none
module rmf_bc_model
  import rmf_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench request
  input wire logic go,
  input wire rmf_cmd_type next_cmd,
  // Terminal side
  output logic cmd_valid,
  output rmf_cmd_type cmd,
  input wire logic status_req,
  output int resp_cnt
);
  // Fields scrambled between commands so stale values never pass
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_valid <= 1'b0;
      cmd <= '0;
      resp_cnt <= 0;
    end
    else
    begin
      cmd_valid <= go;
      cmd <= go ? next_cmd : ~cmd;
      resp_cnt <= resp_cnt + int'(status_req);
    end
  end
endmodule
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for rmf_mode_flag with a reference model.
// Assumes APB answers with pready; commands spaced by ten or more cycles.
`timescale 1ns/10ps
`default_nettype none
module tb
  import rmf_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic pready, pslverr, er, cmd_valid, status_req, ram_wr, irq;
  logic shut_req = 0, shut_bus_b = 0, bus_a_tx_inhibit_pin = 0, bus_b_tx_inhibit_pin = 0;
  logic [15:0] ram_addr, ram_wdata;
  rmf_cmd_type next_cmd = '0, cmd;
  rmf_stat_type status_word;
  rmf_shut_type bus_shut;
  int resp_cnt, mismatches = 0, tests_run = 0, inh = 0, shut = 0, me = 0, bcr = 0;
  logic [31:0] q[$];

  rmf_mode_flag dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_valid(cmd_valid), .cmd(cmd), .shut_req(shut_req), .shut_bus_b(shut_bus_b),
    .bus_a_tx_inhibit_pin(bus_a_tx_inhibit_pin), .bus_b_tx_inhibit_pin(bus_b_tx_inhibit_pin),
    .status_req(status_req), .status_word(status_word), .ram_wr(ram_wr), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .bus_shut(bus_shut), .irq(irq));
  rmf_bc_model bc (.pclk(pclk), .presetn(presetn), .go(go), .next_cmd(next_cmd),
    .cmd_valid(cmd_valid), .cmd(cmd), .status_req(status_req), .resp_cnt(resp_cnt));

  // Clock, RAM write capture, hang limit
  initial forever #50 pclk = ~pclk;
  always @(posedge pclk) if (ram_wr === 1'b1) q.push_back({ram_addr, ram_wdata});
  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    summarize();
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, then one idle edge
  task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h0, i, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(input logic [7:0] i, input logic [31:0] e);
    apb(1'b0, i, 32'h0);
    cmp(rd, e);
  endtask

  // Send one command of mode m and case k, compare against the model
  task automatic run_case(input logic [4:0] m, input int k);
    rmf_cmd_type c;
    logic [63:0] rv;
    logic [31:0] mask, dsc;
    logic [15:0] inf;
    logic [3:0] ev;
    int r0;
    rv = {$urandom, $urandom};
    c = rv[58:0];
    c.mode = m;
    c.tr = (k == 0 || k == 4) ? 1'b1 : (k == 1 ? c.tr : 1'b0);
    c.valid_word = !(k == 1 && c.tr);
    c.data_follows = (k == 4);
    c.illegal = (k == 3);
    mask = $urandom & 32'h0000_000F;
    apb(1'b1, RMF_IDX_CFG1, {31'h0, k == 1 && !c.tr});
    apb(1'b1, RMF_IDX_IRQ_MASK, mask);
    r0 = resp_cnt;
    next_cmd <= c;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    repeat (8) @(posedge pclk);
    ev = 4'h0;
    if (k != 1)
    begin
      dsc = {c.desc_addr, c.desc ^ 16'h0040};
      dsc[4] = (k != 0);
      dsc[5] = c.broadcast_msg_flag && k != 4;
      inf = {c.bus_b, k > 2, k == 3, 1'b0, k == 4, 11'h0};
      ev = {k == 4, k == 3, c.broadcast_msg_flag && k != 4, 1'b1};
      me = (k > 2) ? 1 : (k == 0 && m == RMF_MC_RT_RST) ? 0 : (k == 2 || k == 0) ? 0 : me;
      bcr = (k == 0 && m == RMF_MC_RT_RST) ? 0 : int'(c.broadcast_msg_flag && k != 4);
      if (k == 0 && m == RMF_MC_INH_FLAG) inh = 1;
      if (k == 0 && (m == RMF_MC_OVR_INH || m == RMF_MC_RT_RST)) inh = 0;
      if (k == 0 && (m == RMF_MC_OVR_SHUT || m == RMF_MC_RT_RST)) shut = bus_a_tx_inhibit_pin ? 8 : 0;
      cmp(q.size(), 2);
      if (q.size() == 2)
      begin
        cmp(q[0], dsc);
        cmp(q[1], {c.info_addr, inf});
      end
    end
    else
      cmp(q.size(), 0);
    q.delete();
    cmp(resp_cnt - r0, (k != 1 && k != 4 && !c.broadcast_msg_flag) ? 1 : 0);
    cmp({status_word.me, status_word.bcr, status_word.tflag}, {me[0], bcr[0], inh == 0});
    rchk(RMF_IDX_BITWORD, inh);
    rchk(RMF_IDX_BITREG, shut);
    rchk(RMF_IDX_IRQ_STAT, ev);
    cmp(irq, |(ev & mask[3:0]));
    apb(1'b1, RMF_IDX_IRQ_STAT, ev);
    @(posedge pclk);
    cmp(irq, 0);
    $display("case mode %0d kind %0d done", m, k);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    void'($urandom(54));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, RMF_IDX_STBITS, 32'h1);
    apb(1'b0, 8'h3F, 32'h0);
    cmp(rd, 0); // refused index
    cmp(er, 1); // refused index
    apb(1'b1, RMF_IDX_CFG2, 32'h0);
    shut_bus_b <= 1'b1;
    shut_req <= 1'b1;
    @(posedge pclk);
    shut_req <= 1'b0;
    shut = 5;
    @(posedge pclk);
    rchk(RMF_IDX_BITREG, shut);
    for (int m = 5; m <= 8; m++)
      for (int k = 4; k >= 0; k--)
        run_case(m[4:0], k);
    run_case(RMF_MC_INH_FLAG, 0);
    apb(1'b1, RMF_IDX_CFG1, 32'h2);
    inh = 0;
    rchk(RMF_IDX_BITWORD, 0);
    run_case(RMF_MC_INH_FLAG, 0);
    // Master reset in mid-run also drops the inhibit
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    inh = 0;
    rchk(RMF_IDX_BITWORD, 0);
    apb(1'b1, RMF_IDX_STBITS, 32'h1);
    bus_a_tx_inhibit_pin <= 1'b1;
    repeat (5) @(posedge pclk);
    rchk(RMF_IDX_BITREG, 8);
    run_case(RMF_MC_OVR_SHUT, 0);
    summarize();
  end
endmodule
`default_nettype wire
